//--- design/irq_pkg.sv
package irq_pkg;

  // register byte offsets on the APB side
  localparam logic [7:0] OFF_CORE = 8'h00;
  localparam logic [7:0] OFF_FLAGS_A = 8'h04;
  localparam logic [7:0] OFF_FLAGS_B = 8'h08;
  localparam logic [7:0] OFF_ENABLES_A = 8'h0C;
  localparam logic [7:0] OFF_ENABLES_B = 8'h10;
  localparam logic [7:0] OFF_EDGE_SEL = 8'h14;
  localparam logic [7:0] OFF_PIN_CHANGE_EN = 8'h18;
  localparam logic [7:0] OFF_WAKE_STATUS = 8'h1C;

  // core_irq_control field positions
  localparam int GLOBAL_EN_BIT = 7;
  localparam int PERIPH_EN_BIT = 6;
  localparam int TIMER_EN_BIT = 5;
  localparam int PIN_EN_BIT = 4;
  localparam int PORT_EN_BIT = 3;
  localparam int TIMER_FLAG_BIT = 2;
  localparam int PIN_FLAG_BIT = 1;
  localparam int PORT_FLAG_BIT = 0;

  // wake status field positions
  localparam int WAKE_SET_BIT = 4;
  localparam int WAKE_CLR_BIT = 3;

  // reset values
  localparam logic [7:0] CORE_RESET = 8'h00;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] ENABLES_RESET = 8'h00;
  localparam logic [7:0] PIN_CHANGE_EN_RESET = 8'h00;
  localparam logic [7:0] WAKE_STATUS_RESET = 8'h18;

  // implemented bits of flag/enable register b
  localparam logic [7:0] REG_B_IMPL = 8'hF5;

  localparam logic [12:0] IRQ_VECTOR = 13'h0004;
  localparam logic [7:0] TIMER_MAX = 8'hFF;
  localparam logic [7:0] TIMER_ZERO = 8'h00;

  // instruction cycle: four pclk quarters, sampled at q1
  localparam logic [1:0] Q1 = 2'd0;
  localparam logic [1:0] Q2 = 2'd1;
  localparam int QUARTERS_PER_TCY = 4;
  localparam int DISPATCH_TCY = 3;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SAMPLED = 2'b01,
    ST_HELD = 2'b11
  } disp_state_t;

endpackage : irq_pkg

//--- design/mcu_interrupt_controller.sv
// Summary of operation
// - with global enable set any unmasked request reaches the core; clear blocks dispatch
// - reset clears the global enable
// - return-from-interrupt sets the global enable again
// - dispatch clears global enable, pushes return address, loads vector 0004h
// - external event latency is three cycles synchronous, three to four asynchronous
// - latency does not depend on one or two cycle instructions
// - flags set on their events regardless of any enable bit except the per-pin change enables
// - clearing global enable cancels an imminent dispatch; request stays pending
// - external pin edge: rising when edge-select set, falling when clear
// - valid external edge sets ext pin flag; ext pin enable masks it
// - enabled external pin wakes from sleep; vector only with global enable
// - timer overflow FFh to 00h sets timer flag, gated by its enable
// - port change sets port-change flag; per-pin enable selects pins
// - pin change during a port read at q2 may lose the flag
// - active display segment function disables the external pin interrupt
// - core register holds core flags, enables and global enable
// - peripheral register a holds eight flags with same-position enables
// - peripheral register b holds six flags; two bits read zero
// - on wake, instruction at pc+1 runs first, then vector if enabled
// - interrupt wake sets status bit 4, clears bit 3
module mcu_interrupt_controller
  import irq_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic external_irq_pin,
  input wire logic display_seg_active,
  input wire logic [7:0] change_monitored_port,
  input wire logic port_read,
  input wire logic [7:0] eight_bit_timer,
  input wire logic [7:0] periph_events_a,
  input wire logic [7:0] periph_events_b,
  input wire logic return_from_irq_instr,
  input wire logic sleep_enter,
  input wire logic [12:0] pc_in,
  output logic irq_request,
  output logic irq_dispatch,
  output logic [12:0] stack_push_addr,
  output logic [12:0] pc_load_value,
  output logic wake_pulse,
  output logic sleeping,
  output logic [7:0] wake_status
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [7:0] core;
    logic [7:0] flags_a;
    logic [7:0] flags_b;
    logic [7:0] en_a;
    logic [7:0] en_b;
    logic edge_sel;
    logic [7:0] pin_change_en;
    logic [7:0] wake_status;
    logic pin_s1;
    logic pin_s2;
    logic pin_prev;
    logic [7:0] port_s1;
    logic [7:0] port_s2;
    logic [7:0] port_latch;
    logic [7:0] timer_prev;
    logic [1:0] quarter;
    logic sleeping;
    disp_state_t state;
    logic dispatch;
    logic wake;
    logic [12:0] return_addr;
    logic [12:0] pc_load;
  } ctl_t;

  localparam ctl_t CTL_RESET = '{
    core: CORE_RESET,
    flags_a: FLAGS_RESET,
    flags_b: FLAGS_RESET,
    en_a: ENABLES_RESET,
    en_b: ENABLES_RESET,
    edge_sel: 1'b0,
    pin_change_en: PIN_CHANGE_EN_RESET,
    wake_status: WAKE_STATUS_RESET,
    pin_s1: 1'b0,
    pin_s2: 1'b0,
    pin_prev: 1'b0,
    port_s1: 8'h00,
    port_s2: 8'h00,
    port_latch: 8'h00,
    timer_prev: TIMER_ZERO,
    quarter: Q1,
    sleeping: 1'b0,
    state: ST_IDLE,
    dispatch: 1'b0,
    wake: 1'b0,
    return_addr: 13'h0000,
    pc_load: 13'h0000
  };

  ctl_t ctl_reg;
  ctl_t ctl_next;

  logic wr_en;
  logic addr_hit;
  logic core_hits;
  logic periph_hits;
  logic pending;
  logic wake_req;
  logic ext_evt;
  logic timer_evt;
  logic port_evt;
  logic is_q1;

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: zero wait states, unmapped offsets answer with pslverr

  assign wr_en = psel && penable && pwrite;
  assign pready = 1'b1;

  always_comb
  begin
    addr_hit = 1'b1;
    prdata = 32'h0000_0000;
    unique case (paddr)
      OFF_CORE: prdata[7:0] = ctl_reg.core;
      OFF_FLAGS_A: prdata[7:0] = ctl_reg.flags_a;
      OFF_FLAGS_B: prdata[7:0] = ctl_reg.flags_b;
      OFF_ENABLES_A: prdata[7:0] = ctl_reg.en_a;
      OFF_ENABLES_B: prdata[7:0] = ctl_reg.en_b;
      OFF_EDGE_SEL: prdata[0] = ctl_reg.edge_sel;
      OFF_PIN_CHANGE_EN: prdata[7:0] = ctl_reg.pin_change_en;
      OFF_WAKE_STATUS: prdata[7:0] = ctl_reg.wake_status;
      default: addr_hit = 1'b0;
    endcase
  end

  assign pslverr = psel && penable && !addr_hit;

  ////////////////////////////////////////////////////////////////////////////
  // event detection and request combining

  assign is_q1 = (ctl_reg.quarter == Q1);

  // edge taken from the second sync stage against its own delayed copy
  assign ext_evt = !display_seg_active &&
    (ctl_reg.edge_sel ? (ctl_reg.pin_s2 && !ctl_reg.pin_prev)
                      : (!ctl_reg.pin_s2 && ctl_reg.pin_prev));

  assign timer_evt = (ctl_reg.timer_prev == TIMER_MAX) && (eight_bit_timer == TIMER_ZERO);

  // a read at q2 reloads the latch, so a change landing then is swallowed
  assign port_evt = (|((ctl_reg.port_s2 ^ ctl_reg.port_latch) & ctl_reg.pin_change_en))
    && !(port_read && ctl_reg.quarter == Q2);

  assign core_hits =
    (ctl_reg.core[TIMER_EN_BIT] && ctl_reg.core[TIMER_FLAG_BIT]) ||
    (ctl_reg.core[PIN_EN_BIT] && ctl_reg.core[PIN_FLAG_BIT]) ||
    (ctl_reg.core[PORT_EN_BIT] && ctl_reg.core[PORT_FLAG_BIT]);
  assign periph_hits = |(ctl_reg.flags_a & ctl_reg.en_a) || |(ctl_reg.flags_b & ctl_reg.en_b);
  assign wake_req = core_hits || (ctl_reg.core[PERIPH_EN_BIT] && periph_hits);
  assign pending = ctl_reg.core[GLOBAL_EN_BIT] && wake_req;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    ctl_next = ctl_reg;
    ctl_next.dispatch = 1'b0;
    ctl_next.wake = 1'b0;
    ctl_next.quarter = ctl_reg.quarter + 2'd1;
    ctl_next.pin_s1 = external_irq_pin;
    ctl_next.pin_s2 = ctl_reg.pin_s1;
    ctl_next.pin_prev = ctl_reg.pin_s2;
    ctl_next.port_s1 = change_monitored_port;
    ctl_next.port_s2 = ctl_reg.port_s1;
    ctl_next.timer_prev = eight_bit_timer;
    if (port_read)
    begin
      ctl_next.port_latch = ctl_reg.port_s2;
    end

    if (wr_en)
    begin
      unique case (paddr)
        OFF_CORE: ctl_next.core = pwdata[7:0];
        OFF_FLAGS_A: ctl_next.flags_a = pwdata[7:0];
        OFF_FLAGS_B: ctl_next.flags_b = pwdata[7:0] & REG_B_IMPL;
        OFF_ENABLES_A: ctl_next.en_a = pwdata[7:0];
        OFF_ENABLES_B: ctl_next.en_b = pwdata[7:0] & REG_B_IMPL;
        OFF_EDGE_SEL: ctl_next.edge_sel = pwdata[0];
        OFF_PIN_CHANGE_EN: ctl_next.pin_change_en = pwdata[7:0];
        default: ;
      endcase
    end

    // hardware sets come after the write so a coinciding clear loses
    ctl_next.core[PIN_FLAG_BIT] = ctl_next.core[PIN_FLAG_BIT] || ext_evt;
    ctl_next.core[TIMER_FLAG_BIT] = ctl_next.core[TIMER_FLAG_BIT] || timer_evt;
    ctl_next.core[PORT_FLAG_BIT] = ctl_next.core[PORT_FLAG_BIT] || port_evt;
    ctl_next.flags_a = ctl_next.flags_a | periph_events_a;
    ctl_next.flags_b = ctl_next.flags_b | (periph_events_b & REG_B_IMPL);

    if (return_from_irq_instr)
    begin
      ctl_next.core[GLOBAL_EN_BIT] = 1'b1;
    end

    if (sleep_enter)
    begin
      ctl_next.sleeping = 1'b1;
    end
    else if (ctl_reg.sleeping && wake_req)
    begin
      // the core runs pc+1 now; vectoring, if any, starts at the next q1
      ctl_next.sleeping = 1'b0;
      ctl_next.wake = 1'b1;
      ctl_next.wake_status[WAKE_SET_BIT] = 1'b1;
      ctl_next.wake_status[WAKE_CLR_BIT] = 1'b0;
    end

    // sample at q1, two more instruction cycles, then vector; instruction
    // length is never looked at, so the delay is fixed
    unique case (ctl_reg.state)
      ST_IDLE:
      begin
        // a write clearing the enable on the sampling edge must win as well
        if (is_q1 && pending && ctl_next.core[GLOBAL_EN_BIT] && !ctl_reg.sleeping)
        begin
          ctl_next.state = ST_SAMPLED;
        end
      end
      ST_SAMPLED:
      begin
        if (!ctl_next.core[GLOBAL_EN_BIT])
        begin
          ctl_next.state = ST_IDLE;
        end
        else if (is_q1)
        begin
          ctl_next.state = ST_HELD;
        end
      end
      ST_HELD:
      begin
        if (!ctl_next.core[GLOBAL_EN_BIT])
        begin
          ctl_next.state = ST_IDLE;
        end
        else if (is_q1)
        begin
          ctl_next.state = ST_IDLE;
          ctl_next.core[GLOBAL_EN_BIT] = 1'b0;
          ctl_next.dispatch = 1'b1;
          ctl_next.return_addr = pc_in;
          ctl_next.pc_load = IRQ_VECTOR;
        end
      end
      default: ctl_next.state = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctl_reg <= CTL_RESET;
    end
    else
    begin
      ctl_reg <= ctl_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign irq_request = pending;
  assign irq_dispatch = ctl_reg.dispatch;
  assign stack_push_addr = ctl_reg.return_addr;
  assign pc_load_value = ctl_reg.pc_load;
  assign wake_pulse = ctl_reg.wake;
  assign sleeping = ctl_reg.sleeping;
  assign wake_status = ctl_reg.wake_status;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_dispatch_needs_enable: assert property (
    irq_dispatch |-> $past(ctl_reg.core[GLOBAL_EN_BIT]) && $past(ctl_reg.state) == ST_HELD)
    else $error("dispatch without global enable");

  a_dispatch_clears_enable: assert property (
    irq_dispatch |-> !ctl_reg.core[GLOBAL_EN_BIT] && pc_load_value == IRQ_VECTOR
      && stack_push_addr == $past(pc_in))
    else $error("dispatch did not clear enable or load vector");

  a_return_sets_enable: assert property (
    return_from_irq_instr |=> ctl_reg.core[GLOBAL_EN_BIT] || irq_dispatch)
    else $error("return did not set global enable");

  a_fixed_latency: assert property (
    (ctl_reg.state == ST_SAMPLED && $past(ctl_reg.state) == ST_IDLE)
      ##0 ctl_reg.core[GLOBAL_EN_BIT] [*8] |=> irq_dispatch)
    else $error("dispatch not two cycles after sampling");

  a_enable_clear_cancels: assert property (
    ($fell(ctl_reg.core[GLOBAL_EN_BIT]) && !irq_dispatch) |-> ctl_reg.state == ST_IDLE)
    else $error("dispatch kept after enable cleared");

  a_ext_edge_flag: assert property (
    (ctl_reg.pin_s2 && !ctl_reg.pin_prev && ctl_reg.edge_sel && !display_seg_active)
      |=> ctl_reg.core[PIN_FLAG_BIT])
    else $error("rising edge did not set pin flag");

  a_timer_flag: assert property (
    (ctl_reg.timer_prev == TIMER_MAX && eight_bit_timer == TIMER_ZERO)
      |=> ctl_reg.core[TIMER_FLAG_BIT])
    else $error("timer overflow did not set flag");

  a_wake_status: assert property (
    wake_pulse |-> !sleeping && wake_status[WAKE_SET_BIT] && !wake_status[WAKE_CLR_BIT])
    else $error("wake status bits wrong");

  a_unimpl_zero: assert property (
    ((ctl_reg.flags_b | ctl_reg.en_b) & ~REG_B_IMPL) == 8'h00)
    else $error("unimplemented bits set");

endmodule : mcu_interrupt_controller

//--- verification/core_model.sv
module core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic irq_dispatch,
  input wire logic [12:0] pc_load_value,
  input wire logic return_req,
  output logic [12:0] pc_in,
  output logic return_from_irq_instr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] quarter;
  logic [12:0] saved_pc;
  // one instruction per four quarters; a dispatch takes the vector and keeps the return point
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      quarter <= 2'd0;
      pc_in <= 13'h0000;
      saved_pc <= 13'h0000;
      return_from_irq_instr <= 1'b0;
    end
    else
    begin
      quarter <= quarter + 2'd1;
      return_from_irq_instr <= return_req;
      if (irq_dispatch)
      begin
        saved_pc <= pc_in;
        pc_in <= pc_load_value;
      end
      else if (return_req)
        pc_in <= saved_pc;
      else if (quarter == 2'd3)
        pc_in <= pc_in + 13'h0001;
    end
  end
endmodule : core_model

//--- verification/mcu_interrupt_controller_tb_top.sv
module mcu_interrupt_controller_tb_top
  import irq_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0, presetn, psel, penable, pwrite, pready, pslverr, pin, seg, pread;
  logic rret, rfi, slp, irq_request, irq_dispatch, wake_pulse, sleeping;
  logic [7:0] paddr, port, tmr, ev_a, ev_b, wake_status;
  logic [31:0] pwdata, prdata;
  logic [12:0] pc_in, pc_seen, stack_push_addr, pc_load_value;
  int failures = 0;
  int comparisons = 0;
  always #4 pclk = ~pclk;
  mcu_interrupt_controller i_mcu_interrupt_controller (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .external_irq_pin(pin),
    .display_seg_active(seg), .change_monitored_port(port), .port_read(pread),
    .eight_bit_timer(tmr), .periph_events_a(ev_a), .periph_events_b(ev_b),
    .return_from_irq_instr(rfi), .sleep_enter(slp), .pc_in(pc_in),
    .irq_request(irq_request), .irq_dispatch(irq_dispatch), .stack_push_addr(stack_push_addr),
    .pc_load_value(pc_load_value), .wake_pulse(wake_pulse), .sleeping(sleeping),
    .wake_status(wake_status));
  core_model i_core_model (.pclk(pclk), .presetn(presetn), .irq_dispatch(irq_dispatch),
    .pc_load_value(pc_load_value), .return_req(rret), .pc_in(pc_in),
    .return_from_irq_instr(rfi));
  //////////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask : cyc
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // hold the request until the slave answers
    while (pready !== 1'b1)
    begin
      n++;
      if (n > 20)
      begin
        failures++;
        $display("unexpected pready: expected %h seen %h", 1'b1, pready);
        summarize();
      end
      @(posedge pclk);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, {24'h0000_00, d}, r, e);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk(what, exp, r);
  endtask : rd
  // wake selects the wake pulse instead of the dispatch pulse
  task automatic wait_hi(input bit wake, output int n);
    n = 0;
    do
    begin
      @(posedge pclk);
      pc_seen = pc_in;
      #1;
      n++;
      if (n > 40)
      begin
        failures++;
        $display("unexpected wait: expected %h seen %h", 1, 0);
        summarize();
      end
    end
    while ((wake ? wake_pulse : irq_dispatch) !== 1'b1);
  endtask : wait_hi
  task automatic no_disp(input int k);
    int h = 0;
    repeat (k)
    begin
      @(posedge pclk);
      #1;
      if (irq_dispatch === 1'b1)
        h++;
    end
    chk("dispatch count", 32'h0000_0000, h);
  endtask : no_disp
  task automatic ev(input logic [7:0] a, input logic [7:0] b);
    @(posedge pclk);
    ev_a <= a;
    ev_b <= b;
    @(posedge pclk);
    ev_a <= 8'h00;
    ev_b <= 8'h00;
  endtask : ev
  //////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    int n, b, q;
    logic [31:0] r;
    logic e;
    logic [7:0] ens, gp;
    {presetn, psel, penable, pwrite, pin, seg, pread, rret, slp} = '0;
    {paddr, port, tmr, ev_a, ev_b, pwdata} = '0;
    void'($urandom(34046));
    cyc(2);
    presetn <= 1'b1;
    for (int i = 0; i < 5; i++) rd(8'(4 * i), 32'h0000_0000, "reset value");
    rd(OFF_WAKE_STATUS, 32'h0000_0018, "wake status reset");
    apb(1'b1, 8'h20, 32'h0000_00FF, r, e);
    chk("unmapped error", 1, e);
    wr(OFF_ENABLES_B, 8'hFF);
    rd(OFF_ENABLES_B, 32'h0000_00F5, "enables b");
    ens = 8'($urandom);
    wr(OFF_ENABLES_A, ens);
    rd(OFF_ENABLES_A, {24'h0, ens}, "enables a");
    wr(OFF_WAKE_STATUS, 8'h00);
    rd(OFF_WAKE_STATUS, 32'h0000_0018, "wake status ro");
    $display("test registers done");
    b = $urandom_range(7);
    gp = 8'(1 << b);
    wr(OFF_ENABLES_A, 8'h00);
    ev(gp, 8'hFF);
    rd(OFF_FLAGS_A, {24'h0, gp}, "flags a");
    rd(OFF_FLAGS_B, 32'h0000_00F5, "flags b");
    chk("request masked", 0, irq_request);
    wr(OFF_FLAGS_A, 8'h00);
    wr(OFF_FLAGS_B, 8'h00);
    $display("test flags done");
    wr(OFF_ENABLES_A, ens | gp);
    wr(OFF_CORE, 8'hC0);
    ev(gp, 8'h00);
    wait_hi(1'b0, n);
    chk("return address", pc_seen, stack_push_addr);
    chk("vector", IRQ_VECTOR, pc_load_value);
    rd(OFF_CORE, 32'h0000_0040, "global cleared");
    wr(OFF_FLAGS_A, 8'h00);
    @(posedge pclk);
    rret <= 1'b1;
    @(posedge pclk);
    rret <= 1'b0;
    cyc(2);
    rd(OFF_CORE, 32'h0000_00C0, "global restored");
    no_disp(20);
    ev(gp, 8'h00);
    wr(OFF_CORE, 8'h40);
    no_disp(24);
    rd(OFF_FLAGS_A, {24'h0, gp}, "pending flag");
    wr(OFF_CORE, 8'hC0);
    #1;
    chk("request raised", 1, irq_request);
    wait_hi(1'b0, n);
    wr(OFF_FLAGS_A, 8'h00);
    wr(OFF_CORE, 8'h00);
    $display("test dispatch done");
    for (int es = 0; es < 2; es++)
    begin
      wr(OFF_EDGE_SEL, 8'(es));
      @(posedge pclk);
      pin <= 1'(es);
      cyc(6);
      wr(OFF_CORE, 8'h00);
      pin <= ~1'(es);
      cyc(6);
      rd(OFF_CORE, 32'h0000_0000, "wrong edge");
      pin <= 1'(es);
      cyc(6);
      rd(OFF_CORE, 32'h0000_0002, "valid edge");
      wr(OFF_CORE, 8'h00);
      seg <= 1'b1;
      pin <= ~1'(es);
      cyc(6);
      pin <= 1'(es);
      cyc(6);
      rd(OFF_CORE, 32'h0000_0000, "segment mask");
      seg <= 1'b0;
    end
    $display("test edge done");
    tmr <= 8'hFE;
    cyc(1);
    tmr <= TIMER_MAX;
    cyc(2);
    rd(OFF_CORE, 32'h0000_0000, "no overflow");
    tmr <= TIMER_ZERO;
    cyc(2);
    rd(OFF_CORE, 32'h0000_0004, "overflow");
    q = (b + 1) % 8;
    wr(OFF_PIN_CHANGE_EN, gp);
    wr(OFF_CORE, 8'h00);
    port <= 8'(1 << q);
    cyc(6);
    rd(OFF_CORE, 32'h0000_0000, "masked pin");
    port <= 8'(1 << q) | gp;
    cyc(6);
    rd(OFF_CORE, 32'h0000_0001, "port change");
    pread <= 1'b1;
    cyc(1);
    pread <= 1'b0;
    wr(OFF_CORE, 8'h00);
    $display("test sources done");
    // the pin was left high; drop it so each pass below makes a real rising edge
    pin <= 1'b0;
    for (int k = 0; k < 4; k++)
    begin
      wr(OFF_CORE, 8'h90);
      cyc(k);
      pin <= 1'b1;
      wait_hi(1'b0, n);
      chk("latency", 1, n >= 12 && n <= 16);
      pin <= 1'b0;
    end
    $display("test latency done");
    wr(OFF_CORE, 8'h10);
    cyc(6);
    slp <= 1'b1;
    cyc(1);
    slp <= 1'b0;
    cyc(2);
    chk("sleeping", 1, sleeping);
    pin <= 1'b1;
    wait_hi(1'b1, n);
    rd(OFF_WAKE_STATUS, 32'h0000_0010, "wake status");
    no_disp(20);
    $display("test sleep done");
    summarize();
  end
endmodule : mcu_interrupt_controller_tb_top
